// *** chp_defines.svh ***
// Constants shared by both ends of the card host port.
`ifndef CHP_DEFINES_SVH
`define CHP_DEFINES_SVH
`define CHP_ADDR_W     11
`define CHP_DATA_W     16
`define CHP_TF_W       3
`define CHP_CLK_NS     10
`define CHP_SETUP_NS   30
`define CHP_ACTIVE_NS  80
`define CHP_HOLD_NS    20
`define CHP_SETUP_CYC  ((`CHP_SETUP_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_ACTIVE_CYC ((`CHP_ACTIVE_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_HOLD_CYC   ((`CHP_HOLD_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_CNT_W      4
`define CHP_PIN_IDLE   1'b1
`define CHP_BUS_FLOAT  16'hFFFF
`define CHP_UP_ZERO    8'h00
`endif

// *** chp_pkg.sv ***
// Types shared by both ends of the card host port.
`default_nettype none
package chp_pkg;
    // Operating mode of the card.
    typedef enum logic [1:0] {CHP_MEM = 2'h0, CHP_IO = 2'h1, CHP_IDE = 2'h3} chp_mode_t;
    // Ultra DMA phase in true IDE mode.
    typedef enum logic [1:0] {CHP_PH_NONE = 2'h0, CHP_PH_WR = 2'h1, CHP_PH_RD = 2'h3} chp_phase_t;
    // Address space of one access.
    typedef enum logic [2:0] {CHP_SP_NONE = 3'h0, CHP_SP_ATTR = 3'h1, CHP_SP_MEM = 3'h2,
                              CHP_SP_IO = 3'h3, CHP_SP_TASK = 3'h4} chp_space_t;
    // Host cycle sequencer, Gray coded.
    typedef enum logic [1:0] {CHP_H_IDLE = 2'h0, CHP_H_SETUP = 2'h1, CHP_H_ACTIVE = 2'h3,
                              CHP_H_HOLD = 2'h2} chp_hstate_t;
endpackage
`default_nettype wire

// *** chp_bus_if.sv ***
// Pin-level interface between the host controller and the card.
`timescale 1ns/1ps
`default_nettype none
`include "chp_defines.svh"
interface chp_bus_if;
    import chp_pkg::*;
    // Host driven pins.
    logic [10:0] addr;      // Address lines.
    logic        ce1_n;     // Card enable 1 or chip select 0.
    logic        ce2_n;     // Card enable 2 or chip select 1.
    logic        oe_n;      // Output enable, ATA select in IDE.
    logic        we_n;      // Write enable.
    logic        iord_n;    // I/O read, host strobe, host DMA ready.
    logic        iowr_n;    // I/O write, stop.
    logic        reg_n;     // Register select, DMA acknowledge.
    logic        csel_n;    // Cable select.
    logic [15:0] host_d;    // Host data out.
    logic        host_d_oe; // Host drives data.
    // Card driven pins.
    logic        wait_n;    // Wait, ready, device DMA ready, device strobe.
    logic [15:0] card_d;    // Card data out.
    logic        card_d_oe; // Card drives data.
    logic        bvd1_o;    // Battery detect 1, status change, diag.
    logic        bvd1_oe;   // Drive enable of pin 46.
    logic        bvd2_o;    // Battery detect 2, speaker, active.
    logic        bvd2_oe;   // Drive enable of pin 45.
    // Resolved levels; an undriven line floats high.
    logic [15:0] data;
    logic        bvd1;
    logic        bvd2;
    assign data = card_d_oe ? card_d : (host_d_oe ? host_d : `CHP_BUS_FLOAT);
    assign bvd1 = bvd1_oe ? bvd1_o : `CHP_PIN_IDLE;
    assign bvd2 = bvd2_oe ? bvd2_o : `CHP_PIN_IDLE;
    modport card (input addr, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, reg_n, csel_n, data,
                  output wait_n, card_d, card_d_oe, bvd1_o, bvd1_oe, bvd2_o, bvd2_oe);
    modport host (output addr, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, reg_n, csel_n,
                  host_d, host_d_oe, input wait_n, data, bvd1, bvd2);
endinterface
`default_nettype wire

// *** chp_card.sv ***
// Card end of the host port: pin function mapping and address decode.
`timescale 1ns/1ps
`default_nettype none
`include "chp_defines.svh"
// Contract
// - Ignore cable select in PC card modes.
// - Host ties cable select to A25 or ground.
// - Non-DMA host holds DMA acknowledge high.
// - IDE decodes only A2..A0, eight registers.
// - IDE host grounds address bits above 2.
// - Memory mode drives battery detect 1 high.
// - No burst: read, write strobes, ready.
// - Write burst: host strobe, stop, device ready.
// - Read burst: host ready, stop, device strobe.
// - Memory mode decodes address with register select.
// - I/O mode decodes address as memory mode.
// - Upper byte, second enable only for 16-bit.
// - Memory mode drives battery detect 2 high.
// - I/O mode signals ready, protect changes low.
module chp_card
    import chp_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    // Pins toward the host.
    chp_bus_if.card          bus,
    // Card state and configuration.
    input  wire logic        IO_CFG_IN,
    input  wire logic        RDY_IN,
    input  wire logic        WP_IN,
    input  wire logic        STSCHG_CLR_IN,
    input  wire logic        WAIT_REQ_IN,
    input  wire logic        PDIAG_IN,
    input  wire logic        DASP_IN,
    // Ultra DMA engine.
    input  wire logic        UDMA_WR_IN,
    input  wire logic        UDMA_RD_IN,
    input  wire logic        DDMARDY_IN,
    input  wire logic        DSTROBE_IN,
    input  wire logic [15:0] DMA_RDATA_IN,
    // Register read data.
    input  wire logic [15:0] RD_DATA_IN,
    // Status toward the card core.
    output logic [1:0]       MODE_OUT,
    output logic [1:0]       PHASE_OUT,
    output logic             MASTER_OUT,
    output logic             STSCHG_OUT,
    // Decoded accesses.
    output logic             ACC_RD_OUT,
    output logic             ACC_WR_OUT,
    output logic [2:0]       ACC_SPACE_OUT,
    output logic [10:0]      ACC_ADDR_OUT,
    output logic             ACC_WIDE_OUT,
    output logic [15:0]      WR_DATA_OUT,
    // Ultra DMA data toward the core.
    output logic             DMA_WORD_OUT,
    output logic [15:0]      DMA_WDATA_OUT,
    output logic             HOST_RDY_OUT,
    output logic             STOP_OUT
);
    chp_mode_t  mode_r;        // Current operating mode.
    logic       strap_done_r;  // IDE strap has been caught.
    logic       ide_r;         // Strap level of ATA select.
    chp_phase_t phase_r;       // Current burst phase.
    logic       sel;           // Any card enable active.
    logic       rd_act;        // A read cycle is in progress.
    logic       wr_act;        // A write cycle is in progress.
    logic       busy;          // Any cycle in progress.
    logic       rd_prev_r;     // Read activity last cycle.
    logic       wr_prev_r;     // Write activity last cycle.
    chp_space_t space;         // Space of the current cycle.
    logic       hs_prev_r;     // Host strobe last cycle.
    logic       rdy_prev_r;    // Ready level last cycle.
    logic       wp_prev_r;     // Protect level last cycle.
    logic       stschg_r;      // Sticky status change.
    logic [15:0] d_out_r;      // Data presented on reads.
    logic       wait_r;        // Level of the shared wait pin.

    // Space decode for PC card cycles; both PC modes share it.
    function automatic chp_space_t pc_space(input logic reg_n, input logic io_strobe);
        chp_space_t s;
        s = CHP_SP_MEM;
        if (io_strobe)
            s = CHP_SP_IO;
        else if (!reg_n)
            s = CHP_SP_ATTR;
        return s;
    endfunction

    // Cycle detection. In IDE only the I/O strobes count, and only outside a burst.
    always_comb
    begin
        sel    = !bus.ce1_n || !bus.ce2_n;
        rd_act = 1'b0;
        wr_act = 1'b0;
        space  = CHP_SP_NONE;
        if (mode_r == CHP_IDE)
        begin
            if (phase_r == CHP_PH_NONE && sel)
            begin
                rd_act = !bus.iord_n;
                wr_act = !bus.iowr_n;
                space  = CHP_SP_TASK;
            end
        end
        else if (sel)
        begin
            rd_act = !bus.oe_n || (mode_r == CHP_IO && !bus.iord_n);
            wr_act = !bus.we_n || (mode_r == CHP_IO && !bus.iowr_n);
            space  = pc_space(bus.reg_n,
                              mode_r == CHP_IO && !(bus.iord_n && bus.iowr_n));
        end
    end
    assign busy = rd_act || wr_act;

    // Mode tracking. The ATA select strap is caught on the first edge after reset.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            strap_done_r <= 1'b0;
            ide_r        <= 1'b0;
            mode_r       <= CHP_MEM;
        end
        else
        begin
            if (!strap_done_r)
            begin
                strap_done_r <= 1'b1;
                ide_r        <= !bus.oe_n;
            end
            if (!busy)
                mode_r <= (strap_done_r && ide_r) ? CHP_IDE :
                          (IO_CFG_IN ? CHP_IO : CHP_MEM);
        end
    end

    // Burst phase. Entry waits for the PIO cycle to end so a strobe never changes meaning.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            phase_r <= CHP_PH_NONE;
        else if (!busy)
        begin
            if (mode_r != CHP_IDE)
                phase_r <= CHP_PH_NONE;
            else if (UDMA_WR_IN)
                phase_r <= CHP_PH_WR;
            else if (UDMA_RD_IN)
                phase_r <= CHP_PH_RD;
            else
                phase_r <= CHP_PH_NONE;
        end
    end

    // Access reporting: read pulse at cycle start, write pulse when the strobe rises.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rd_prev_r     <= 1'b0;
            wr_prev_r     <= 1'b0;
            ACC_RD_OUT    <= 1'b0;
            ACC_WR_OUT    <= 1'b0;
            ACC_SPACE_OUT <= CHP_SP_NONE;
            ACC_ADDR_OUT  <= '0;
            ACC_WIDE_OUT  <= 1'b0;
            WR_DATA_OUT   <= '0;
        end
        else
        begin
            rd_prev_r  <= rd_act;
            wr_prev_r  <= wr_act;
            ACC_RD_OUT <= rd_act && !rd_prev_r;
            ACC_WR_OUT <= !wr_act && wr_prev_r;
            if (busy)
            begin
                ACC_SPACE_OUT <= space;
                ACC_WIDE_OUT  <= !bus.ce1_n && !bus.ce2_n;
                // only the low three bits in IDE
                if (mode_r == CHP_IDE)
                    ACC_ADDR_OUT <= {`CHP_UP_ZERO, bus.addr[`CHP_TF_W-1:0]};
                else
                    ACC_ADDR_OUT <= bus.addr;
            end
            // Write data is sampled while the strobe is low; the last sample wins.
            if (wr_act)
                WR_DATA_OUT <= bus.data;
        end
    end

    // Read data source; burst data during a read burst.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            d_out_r <= '0;
        else
            d_out_r <= (phase_r == CHP_PH_RD) ? DMA_RDATA_IN : RD_DATA_IN;
    end
    assign bus.card_d    = d_out_r;
    // card drives data in read burst
    assign bus.card_d_oe = rd_act || (phase_r == CHP_PH_RD && !bus.reg_n);

    // Burst receive side: each host strobe edge carries one word.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            hs_prev_r     <= `CHP_PIN_IDLE;
            DMA_WORD_OUT  <= 1'b0;
            DMA_WDATA_OUT <= '0;
            HOST_RDY_OUT  <= 1'b0;
            STOP_OUT      <= 1'b0;
        end
        else
        begin
            hs_prev_r    <= bus.iord_n;
            // host strobe and stop in write burst
            DMA_WORD_OUT <= (phase_r == CHP_PH_WR) && (bus.iord_n != hs_prev_r);
            if (phase_r == CHP_PH_WR && bus.iord_n != hs_prev_r)
                DMA_WDATA_OUT <= bus.data;
            // host ready and stop in read burst
            HOST_RDY_OUT <= (phase_r == CHP_PH_RD) && !bus.iord_n;
            STOP_OUT     <= (phase_r != CHP_PH_NONE) && bus.iowr_n;
        end
    end

    // Shared wait pin; its meaning follows mode and phase.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            wait_r <= `CHP_PIN_IDLE;
        else if (mode_r != CHP_IDE)
            wait_r <= !WAIT_REQ_IN;
        else
        begin
            unique case (phase_r)
                CHP_PH_NONE: wait_r <= RDY_IN;
                CHP_PH_WR:   wait_r <= !DDMARDY_IN;
                CHP_PH_RD:   wait_r <= DSTROBE_IN;
                default:     wait_r <= `CHP_PIN_IDLE;
            endcase
        end
    end
    assign bus.wait_n = wait_r;

    // Status change. A new change in the clear cycle wins over the clear.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rdy_prev_r <= 1'b0;
            wp_prev_r  <= 1'b0;
            stschg_r   <= 1'b0;
        end
        else
        begin
            rdy_prev_r <= RDY_IN;
            wp_prev_r  <= WP_IN;
            if (mode_r == CHP_IO && (RDY_IN != rdy_prev_r || WP_IN != wp_prev_r))
                stschg_r <= 1'b1;
            else if (STSCHG_CLR_IN || mode_r != CHP_IO)
                stschg_r <= 1'b0;
        end
    end
    assign STSCHG_OUT = stschg_r;

    // Pins 45 and 46: totem pole in PC modes, open drain in IDE.
    always_comb
    begin
        unique case (mode_r)
            CHP_MEM:
            begin
                bus.bvd1_o  = 1'b1;
                bus.bvd1_oe = 1'b1;
                bus.bvd2_o  = 1'b1;
                bus.bvd2_oe = 1'b1;
            end
            CHP_IO:
            begin
                bus.bvd1_o  = !stschg_r;
                bus.bvd1_oe = 1'b1;
                // No audio, so the speaker line stays negated.
                bus.bvd2_o  = 1'b1;
                bus.bvd2_oe = 1'b1;
            end
            default:
            begin
                bus.bvd1_o  = 1'b0;
                bus.bvd1_oe = PDIAG_IN;
                bus.bvd2_o  = 1'b0;
                bus.bvd2_oe = DASP_IN;
            end
        endcase
    end

    // cable select only counts in IDE
    assign MASTER_OUT = (mode_r == CHP_IDE) && !bus.csel_n;
    assign MODE_OUT   = mode_r;
    assign PHASE_OUT  = phase_r;
endmodule
`default_nettype wire

// *** chp_host.sv ***
// Host end of the card port: cycle sequencer and burst pin drive.
`timescale 1ns/1ps
`default_nettype none
`include "chp_defines.svh"
module chp_host
    import chp_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    // Pins toward the card.
    chp_bus_if.host          bus,
    // Setup.
    input  wire logic [1:0]  MODE_IN,
    input  wire logic        A25_IN,
    input  wire logic        USE_DMA_IN,
    // Command port.
    input  wire logic        CMD_VALID_IN,
    output logic             CMD_READY_OUT,
    input  wire logic        CMD_WRITE_IN,
    input  wire logic [2:0]  CMD_SPACE_IN,
    input  wire logic [10:0] CMD_ADDR_IN,
    input  wire logic [15:0] CMD_WDATA_IN,
    input  wire logic        CMD_WIDE_IN,
    output logic             RSP_VALID_OUT,
    output logic [15:0]      RSP_DATA_OUT,
    // Ultra DMA.
    input  wire logic [1:0]  PHASE_IN,
    input  wire logic        DMA_ACK_IN,
    input  wire logic        HSTROBE_IN,
    input  wire logic        HDMARDY_IN,
    input  wire logic        STOP_IN,
    input  wire logic [15:0] DMA_WDATA_IN,
    output logic             DMA_WORD_OUT,
    output logic [15:0]      DMA_RDATA_OUT,
    output logic             DDMARDY_OUT
);
    chp_hstate_t state_r;            // Cycle sequencer.
    logic [`CHP_CNT_W-1:0] cnt_r;    // Cycles left in this state.
    logic        write_r;            // Current cycle writes.
    chp_space_t  space_r;            // Current cycle space.
    logic [10:0] addr_r;             // Current cycle address.
    logic [15:0] wdata_r;            // Current write data.
    logic        wide_r;             // Current cycle is 16-bit.
    logic        strobe;             // Strobe low this cycle.
    logic        ide;                // True IDE selected.
    logic        ready;              // Card lets the strobe end.
    logic        io_sp;              // Cycle uses I/O strobes.
    logic        ds_prev_r;          // Device strobe last cycle.

    assign ide   = MODE_IN == CHP_IDE;
    assign strobe = state_r == CHP_H_ACTIVE;
    assign ready = bus.wait_n;
    assign io_sp = space_r == CHP_SP_IO || space_r == CHP_SP_TASK;
    // Commands are taken only outside a burst.
    assign CMD_READY_OUT = state_r == CHP_H_IDLE && PHASE_IN == CHP_PH_NONE;

    // Cycle sequencer: setup, strobe, hold; the strobe stretches while the card waits.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            state_r       <= CHP_H_IDLE;
            cnt_r         <= '0;
            write_r       <= 1'b0;
            space_r       <= CHP_SP_NONE;
            addr_r        <= '0;
            wdata_r       <= '0;
            wide_r        <= 1'b0;
            RSP_VALID_OUT <= 1'b0;
            RSP_DATA_OUT  <= '0;
        end
        else
        begin
            RSP_VALID_OUT <= 1'b0;
            unique case (state_r)
                CHP_H_IDLE:
                    if (CMD_VALID_IN && CMD_READY_OUT)
                    begin
                        state_r <= CHP_H_SETUP;
                        cnt_r   <= `CHP_CNT_W'(`CHP_SETUP_CYC - 1);
                        write_r <= CMD_WRITE_IN;
                        space_r <= chp_space_t'(CMD_SPACE_IN);
                        addr_r  <= CMD_ADDR_IN;
                        wdata_r <= CMD_WDATA_IN;
                        wide_r  <= CMD_WIDE_IN;
                    end
                CHP_H_SETUP:
                    if (cnt_r == '0)
                    begin
                        state_r <= CHP_H_ACTIVE;
                        cnt_r   <= `CHP_CNT_W'(`CHP_ACTIVE_CYC - 1);
                    end
                    else
                        cnt_r <= cnt_r - 1'b1;
                CHP_H_ACTIVE:
                    if (cnt_r != '0)
                        cnt_r <= cnt_r - 1'b1;
                    else if (ready)
                    begin
                        state_r       <= CHP_H_HOLD;
                        cnt_r         <= `CHP_CNT_W'(`CHP_HOLD_CYC - 1);
                        RSP_VALID_OUT <= !write_r;
                        RSP_DATA_OUT  <= wide_r ? bus.data : {`CHP_UP_ZERO, bus.data[7:0]};
                    end
                CHP_H_HOLD:
                    if (cnt_r == '0)
                        state_r <= CHP_H_IDLE;
                    else
                        cnt_r <= cnt_r - 1'b1;
            endcase
        end
    end

    // Pin drive; card enables only while a cycle is open.
    always_comb
    begin
        bus.addr  = ide ? {`CHP_UP_ZERO, addr_r[`CHP_TF_W-1:0]} : addr_r;
        bus.ce1_n = state_r == CHP_H_IDLE;
        bus.ce2_n = state_r == CHP_H_IDLE || !wide_r;
        bus.oe_n  = ide ? 1'b0 : !(strobe && !write_r && !io_sp);
        bus.we_n  = ide ? `CHP_PIN_IDLE : !(strobe && write_r && !io_sp);
        bus.reg_n = ide ? !(USE_DMA_IN && DMA_ACK_IN) : !(space_r == CHP_SP_ATTR || io_sp);
        // cable select from A25 in PC modes
        bus.csel_n = ide ? 1'b0 : A25_IN;
        unique case (chp_phase_t'(PHASE_IN))
            CHP_PH_WR:
            begin
                bus.iord_n = HSTROBE_IN;
                bus.iowr_n = STOP_IN;
            end
            CHP_PH_RD:
            begin
                bus.iord_n = !HDMARDY_IN;
                bus.iowr_n = STOP_IN;
            end
            default:
            begin
                bus.iord_n = !(strobe && !write_r && io_sp);
                bus.iowr_n = !(strobe && write_r && io_sp);
            end
        endcase
        bus.host_d    = (PHASE_IN == CHP_PH_WR) ? DMA_WDATA_IN : wdata_r;
        bus.host_d_oe = (PHASE_IN == CHP_PH_WR) || (write_r && state_r != CHP_H_IDLE);
    end

    // Read burst capture on each device strobe edge.
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ds_prev_r     <= `CHP_PIN_IDLE;
            DMA_WORD_OUT  <= 1'b0;
            DMA_RDATA_OUT <= '0;
        end
        else
        begin
            ds_prev_r    <= bus.wait_n;
            DMA_WORD_OUT <= PHASE_IN == CHP_PH_RD && bus.wait_n != ds_prev_r;
            if (PHASE_IN == CHP_PH_RD && bus.wait_n != ds_prev_r)
                DMA_RDATA_OUT <= bus.data;
        end
    end
    assign DDMARDY_OUT = PHASE_IN == CHP_PH_WR && !bus.wait_n;
endmodule
`default_nettype wire

// *** chp_assertions.sv ***
// Pin checks on the link between host and card ends.
`timescale 1ns/1ps
`default_nettype none
module chp_assertions (
    // Clock, reset and watched pins.
    input wire logic        CLK_IN,
    input wire logic        RESETN_IN,
    input wire logic [10:0] addr,
    input wire logic        ce1_n,
    input wire logic        ce2_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        iord_n,
    input wire logic        card_d_oe,
    input wire logic        host_d_oe
);
    // Any enable low marks a bus cycle, so strap edges do not count.
    logic sel;
    assign sel = !(ce1_n && ce2_n);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence wr_active;
        !we_n [*8];
    endsequence
    wr_setup_a: assert property ($fell(we_n) |-> sel && $past(sel, 2))
        else $error("write strobe without setup");
    wr_width_a: assert property ($fell(we_n) |-> wr_active)
        else $error("write strobe too short");
    wr_hold_a: assert property ($rose(we_n) |-> sel)
        else $error("enable dropped with strobe");
    rd_width_a: assert property ($fell(oe_n) && sel |-> !oe_n [*8])
        else $error("read strobe too short");
    io_width_a: assert property ($fell(iord_n) && sel |-> !iord_n [*8])
        else $error("io read strobe too short");
    rd_drive_a: assert property ($fell(oe_n) && sel |-> card_d_oe)
        else $error("card not driving read");
    addr_hold_a: assert property (!we_n && sel ##1 !we_n |-> $stable(addr))
        else $error("address moved in cycle");
    no_clash_a: assert property (card_d_oe |-> !host_d_oe)
        else $error("both ends drive data");
endmodule
`default_nettype wire

// *** card_host_port_pin_mode_mapping_tb.sv ***
// Bench joining the host end and the card end of the port.
`timescale 1ns/1ps
`default_nettype none
module card_host_port_pin_mode_mapping_tb;
    import chp_pkg::*;
    logic CLK_IN = 0, RESETN_IN = 0, IO_CFG_IN = 0, RDY_IN = 0, WP_IN = 0, STSCHG_CLR_IN = 0;
    logic WAIT_REQ_IN = 0, PDIAG_IN = 0, DASP_IN = 0, UDMA_WR_IN = 0, UDMA_RD_IN = 0;
    logic DDMARDY_IN = 0, DSTROBE_IN = 0, A25_IN = 0, USE_DMA_IN = 0, DMA_ACK_IN = 0;
    logic CMD_VALID_IN = 0, CMD_WRITE_IN = 0, CMD_WIDE_IN = 0, HSTROBE_IN = 1;
    logic HDMARDY_IN = 0, STOP_IN = 0, CMD_READY_OUT, RSP_VALID_OUT, DDMARDY_OUT;
    logic MASTER_OUT, STSCHG_OUT, ACC_RD_OUT, ACC_WR_OUT, ACC_WIDE_OUT, HOST_RDY_OUT, STOP_OUT;
    logic [15:0] DMA_RDATA_IN = 0, RD_DATA_IN = 0, CMD_WDATA_IN = 0, DMA_WDATA_IN = 0;
    logic [15:0] RSP_DATA_OUT, WR_DATA_OUT, DMA_WDATA_OUT, DMA_RDATA_OUT, g_a, g_d, g_sp, rsp;
    logic [1:0]  MODE_IN = 0, PHASE_IN = 0, MODE_OUT, PHASE_OUT;
    logic [2:0]  CMD_SPACE_IN = 0, ACC_SPACE_OUT;
    logic [10:0] CMD_ADDR_IN = 0, ACC_ADDR_OUT;
    int          bad_count = 0;
    int          n_checks = 0;
    chp_bus_if bus ();
    chp_card u_chp_card (.*, .bus(bus), .DMA_WORD_OUT());
    chp_host u_chp_host (.*, .bus(bus), .DMA_WORD_OUT());
    chp_assertions u_chp_assertions (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .addr(bus.addr),
        .ce1_n(bus.ce1_n), .ce2_n(bus.ce2_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
        .iord_n(bus.iord_n), .card_d_oe(bus.card_d_oe), .host_d_oe(bus.host_d_oe));
    // 100 MHz clock.
    always #5 CLK_IN = ~CLK_IN;
    // Inputs move 1 ns after the edge so no race with the design.
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Reset with a chosen host mode; the IDE strap is seen after release.
    task automatic rst(input logic [1:0] m);
        MODE_IN = m;
        RESETN_IN = 1'b0;
        cyc(3);
        RESETN_IN = 1'b1;
        cyc(5);
    endtask
    // One host command, held until taken, then the card side is watched.
    task automatic acc(input logic w, input logic [2:0] s, input logic [10:0] a,
                       input logic [15:0] d, input logic wd);
        {CMD_WRITE_IN, CMD_SPACE_IN, CMD_ADDR_IN, CMD_WDATA_IN, CMD_WIDE_IN} = {w, s, a, d, wd};
        // Stale captures from the previous call must not satisfy this one.
        {g_sp, g_a, g_d, rsp} = '1;
        CMD_VALID_IN = 1'b1;
        while (CMD_READY_OUT !== 1'b1)
            cyc(1);
        cyc(1);
        CMD_VALID_IN = 1'b0;
        repeat (20)
        begin
            if (ACC_RD_OUT || ACC_WR_OUT)
                {g_sp, g_a, g_d} = {13'h0, ACC_SPACE_OUT, 5'h0, ACC_ADDR_OUT, WR_DATA_OUT};
            if (RSP_VALID_OUT)
                rsp = RSP_DATA_OUT;
            cyc(1);
        end
    endtask
    initial
    begin
        rst(CHP_MEM);
        // Memory then I/O mode must decode alike.
        for (int i = 0; i < 2; i++)
        begin
            IO_CFG_IN = i[0];
            A25_IN = i[0];
            acc(1'b1, CHP_SP_MEM, 11'h7FF, 16'hAB12, 1'b1);
            chk(g_sp, CHP_SP_MEM);
            chk(g_a, 16'h07FF);
            chk(g_d, 16'hAB12);
            chk(MASTER_OUT, 1'b0);
            chk(bus.csel_n, i[0]);
            chk(ACC_WIDE_OUT, 1'b1);
        end
        RD_DATA_IN = 16'h5AC3;
        acc(1'b0, CHP_SP_IO, 11'h3F7, 16'h0, 1'b0);
        chk(g_sp, CHP_SP_IO);
        chk(rsp, 16'h00C3);
        chk(ACC_WIDE_OUT, 1'b0);
        RDY_IN = 1'b1;
        cyc(3);
        chk(bus.bvd1, 1'b0);
        STSCHG_CLR_IN = 1'b1;
        cyc(1);
        STSCHG_CLR_IN = 1'b0;
        cyc(2);
        chk(STSCHG_OUT, 1'b0);
        IO_CFG_IN = 1'b0;
        RD_DATA_IN = 16'h1E96;
        acc(1'b0, CHP_SP_ATTR, 11'h200, 16'h0, 1'b0);
        chk(g_sp, CHP_SP_ATTR);
        chk(rsp, 16'h0096);
        chk({bus.bvd1, bus.bvd2}, 2'h3);
        // IDE: upper address bits set on purpose must be dropped.
        rst(CHP_IDE);
        chk(MODE_OUT, CHP_IDE);
        chk(MASTER_OUT, 1'b1);
        // Acknowledge raised without DMA enabled; the host must still hold the pin high.
        DMA_ACK_IN = 1'b1;
        acc(1'b0, CHP_SP_TASK, 11'h7FD, 16'h0, 1'b0);
        chk(g_a, 16'h0005);
        chk(g_sp, CHP_SP_TASK);
        chk(bus.reg_n, 1'b1);
        chk(bus.addr, 16'h0005);
        {USE_DMA_IN, DMA_ACK_IN, UDMA_WR_IN, DDMARDY_IN, PHASE_IN} = {4'hF, CHP_PH_WR};
        cyc(3);
        chk(PHASE_OUT, CHP_PH_WR);
        chk(bus.wait_n, 1'b0);
        chk(DDMARDY_OUT, 1'b1);
        chk(CMD_READY_OUT, 1'b0);
        DMA_WDATA_IN = 16'hC33C;
        HSTROBE_IN = 1'b0;
        STOP_IN = 1'b1;
        cyc(3);
        chk(DMA_WDATA_OUT, 16'hC33C);
        chk(STOP_OUT, 1'b1);
        {STOP_IN, UDMA_WR_IN, UDMA_RD_IN, HDMARDY_IN, PHASE_IN} = {4'h3, CHP_PH_RD};
        DMA_RDATA_IN = 16'h9669;
        cyc(3);
        chk(PHASE_OUT, CHP_PH_RD);
        chk(HOST_RDY_OUT, 1'b1);
        DSTROBE_IN = 1'b1;
        cyc(4);
        chk(DMA_RDATA_OUT, 16'h9669);
        summarize();
    end
    // Watchdog well past the expected run of about 140 cycles.
    initial
    begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
